//--- mic_combiner.sv
// module: interrupt collection, gating and vectoring logic with an apb register slave
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module mic_combiner #(
   parameter int PORT_W = 6,
   parameter int EXT_PIN = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [PORT_W-1:0] port_in,
   input wire logic [1:0] q_phase,
   input wire logic timer0_wrap,
   input wire mic_pkg::mic_periph_ev_t periph_ev,
   input wire logic sleeping,
   input wire logic return_from_irq_instr,
   input wire logic gie_clear_instr,
   output mic_pkg::mic_core_out_t core_out_q,
   output logic [15:0] vector_addr_q
);
   // control and flag registers
   logic [7:0] icr_q; // interrupt_control
   logic [7:0] pflag_q; // peripheral_flags
   logic [7:0] pen_q; // peripheral_enables
   logic [31:0] aux_q; // polarity, analog select, change mask
   logic [PORT_W-1:0] dig_in; // digital view of the port
   logic [PORT_W-1:0] last_port_q; // change latch
   logic ext_prev_q; // previous external level
   logic ext_edge, port_change, port_read, acc, wr;
   logic [7:0] idx;
   logic any_core, any_periph, req_now;
   logic [1:0] lat_q; // cycles left before vectoring
   logic gie_hold_q; // one cycle deferral after gie clear

   // decode a word address into its register index
   function automatic logic [7:0] reg_index(input logic [11:0] a);
      reg_index = a[9:2];
   endfunction : reg_index

   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign idx = reg_index(paddr);
   // port read is a read access at the port value register, taken in any phase
   assign port_read = acc && !pwrite && idx == mic_pkg::IDX_PORT_VALUE;

   // analog pins read zero through the digital path
   assign dig_in = port_in & ~aux_q[mic_pkg::AUX_ANALOG_SELECT_LSB +: PORT_W];
   // edge on the external pin in the chosen direction
   assign ext_edge = aux_q[mic_pkg::AUX_POL] ? (dig_in[EXT_PIN] && !ext_prev_q)
                                             : (!dig_in[EXT_PIN] && ext_prev_q);
   // a masked pin differing from its latch; a change hidden by a port value read may be lost
   assign port_change = |((dig_in ^ last_port_q) & aux_q[mic_pkg::AUX_MASK_LSB +: PORT_W])
                        && !port_read;

   // enabled flags combined into request and wake
   assign any_core = (icr_q[mic_pkg::ICR_EXTF] && icr_q[mic_pkg::ICR_EXTE])
                  || (icr_q[mic_pkg::ICR_T0F] && icr_q[mic_pkg::ICR_TIMER0_OVERFLOW_ENABLE])
                  || (icr_q[mic_pkg::ICR_PCF] && icr_q[mic_pkg::ICR_PCE]);
   assign any_periph = icr_q[mic_pkg::ICR_PERIPHERAL_IRQ_ENABLE] && |(pflag_q & pen_q & mic_pkg::PF_MASK);
   assign req_now = icr_q[mic_pkg::ICR_GIE] && !gie_hold_q && (any_core || any_periph);

   // apb slave: zero wait states, unmapped addresses answer with an error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            // setup cycle: prepare answer for the access cycle
            case (reg_index(paddr))
               mic_pkg::IDX_INTERRUPT_CONTROL: prdata <= {24'h000000, icr_q};
               mic_pkg::IDX_PERIPHERAL_FLAGS: prdata <= {24'h000000, pflag_q};
               mic_pkg::IDX_PERIPHERAL_ENABLES: prdata <= {24'h000000, pen_q};
               mic_pkg::IDX_CONTROL_AUX: prdata <= aux_q;
               mic_pkg::IDX_CORE_STATUS: prdata <= {28'h0000000, core_out_q};
               mic_pkg::IDX_PORT_VALUE: prdata <= {{(32-PORT_W){1'b0}}, dig_in};
               default: begin
                  prdata <= 32'h00000000;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end

   // interrupt control: hardware sets win over software writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         icr_q <= mic_pkg::RESET_BYTE;
      end else begin
         logic [7:0] nx;
         nx = icr_q;
         if (wr && pready && idx == mic_pkg::IDX_INTERRUPT_CONTROL) begin
            nx = pwdata[7:0]; // flags cleared only by software
         end
         if (gie_clear_instr) begin
            nx[mic_pkg::ICR_GIE] = 1'b0;
         end
         if (return_from_irq_instr) begin
            nx[mic_pkg::ICR_GIE] = 1'b1;
         end
         if (lat_q == 2'd1) begin
            nx[mic_pkg::ICR_GIE] = 1'b0;
         end
         // pin flag only taken in q4/q1, so it is stable when sampled at q1
         if (ext_edge && (q_phase == mic_pkg::PH_Q4 || q_phase == mic_pkg::PH_Q1)) begin
            nx[mic_pkg::ICR_EXTF] = 1'b1;
         end
         if (timer0_wrap) begin
            nx[mic_pkg::ICR_T0F] = 1'b1;
         end
         if (port_change) begin
            nx[mic_pkg::ICR_PCF] = 1'b1;
         end
         icr_q <= nx;
      end
   end

   // peripheral flags: events set, software clears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pflag_q <= mic_pkg::RESET_BYTE;
      end else begin
         logic [7:0] nf;
         nf = pflag_q;
         if (wr && pready && idx == mic_pkg::IDX_PERIPHERAL_FLAGS) begin
            nf = pwdata[7:0] & mic_pkg::PF_MASK;
         end
         nf[mic_pkg::PF_CONV] = nf[mic_pkg::PF_CONV] | periph_ev.conv_done;
         nf[mic_pkg::PF_NVM] = nf[mic_pkg::PF_NVM] | periph_ev.nvm_done;
         nf[mic_pkg::PF_CMP] = nf[mic_pkg::PF_CMP] | periph_ev.comparator;
         nf[mic_pkg::PF_TMR1] = nf[mic_pkg::PF_TMR1] | periph_ev.timer1_ovf;
         pflag_q <= nf;
      end
   end

   // enables and auxiliary control, written by software only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pen_q <= mic_pkg::RESET_BYTE;
         aux_q <= mic_pkg::AUX_RESET;
      end else if (wr && pready) begin
         if (idx == mic_pkg::IDX_PERIPHERAL_ENABLES) begin
            pen_q <= pwdata[7:0] & mic_pkg::PF_MASK;
         end
         if (idx == mic_pkg::IDX_CONTROL_AUX) begin
            aux_q <= pwdata;
         end
      end
   end

   // edge and change history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_prev_q <= 1'b0;
         last_port_q <= '0;
      end else begin
         ext_prev_q <= dig_in[EXT_PIN];
         if (port_read) begin
            last_port_q <= dig_in;
         end
      end
   end

   // deferral: a gie clear hides a request due next cycle; flags stay pending
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gie_hold_q <= 1'b0;
      end else begin
         gie_hold_q <= gie_clear_instr;
      end
   end

   // latency counter: request seen at q1, vector after fixed further cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lat_q <= 2'd0;
      end else if (lat_q != 2'd0) begin
         lat_q <= lat_q - 2'd1;
      end else if (req_now && q_phase == mic_pkg::PH_Q1 && !gie_clear_instr) begin
         lat_q <= 2'd3;
      end
   end

   // outputs to sequencer, all registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_out_q <= '0;
         vector_addr_q <= 16'h0000;
      end else begin
         core_out_q.irq_req <= req_now;
         core_out_q.wake <= sleeping && (any_core || any_periph);
         core_out_q.vector_load <= lat_q == 2'd1;
         core_out_q.push_pc <= lat_q == 2'd1;
         vector_addr_q <= mic_pkg::VECTOR_ADDR;
      end
   end

   // checks
   ext_flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      ext_edge && q_phase == mic_pkg::PH_Q1 |=> icr_q[mic_pkg::ICR_EXTF])
      else $error("pin edge did not set flag");
   t0_flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      timer0_wrap |=> icr_q[mic_pkg::ICR_T0F]) else $error("timer0 flag lost");
   conv_flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      periph_ev.conv_done |=> pflag_q[mic_pkg::PF_CONV]) else $error("conv flag lost");
   ext_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      !icr_q[mic_pkg::ICR_EXTE] && !icr_q[mic_pkg::ICR_TIMER0_OVERFLOW_ENABLE] && !icr_q[mic_pkg::ICR_PCE]
      && !icr_q[mic_pkg::ICR_PERIPHERAL_IRQ_ENABLE] |=> !core_out_q.irq_req)
      else $error("request while disabled");
   vec_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      lat_q == 2'd1 && !return_from_irq_instr |=> !icr_q[mic_pkg::ICR_GIE]
      && core_out_q.vector_load) else $error("vector without gie clear");
   vec_latency_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(lat_q == 2'd3) |-> ##3 core_out_q.vector_load)
      else $error("vector latency wrong");
   reti_gie_a: assert property (@(posedge pclk) disable iff (!presetn)
      return_from_irq_instr && lat_q != 2'd1 |=> icr_q[mic_pkg::ICR_GIE])
      else $error("return did not set gie");
   defer_a: assert property (@(posedge pclk) disable iff (!presetn)
      gie_clear_instr && lat_q == 2'd0 |=> !core_out_q.vector_load ##1 !core_out_q.irq_req)
      else $error("interrupt not deferred");
   cov_vector_c: cover property (@(posedge pclk) disable iff (!presetn) core_out_q.vector_load);
   cov_wake_c: cover property (@(posedge pclk) disable iff (!presetn) core_out_q.wake);
   cov_change_c: cover property (@(posedge pclk) disable iff (!presetn) port_change);
endmodule : mic_combiner

//--- mic_pkg.sv
// package: register map, field positions and shared types of the interrupt combiner
package mic_pkg;
   // register indices (printed offsets are not all multiples of four)
   localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0B;
   localparam logic [7:0] IDX_PERIPHERAL_FLAGS = 8'h0C;
   localparam logic [7:0] IDX_PERIPHERAL_ENABLES = 8'h8C;
   localparam logic [7:0] IDX_CONTROL_AUX = 8'hF0; // polarity, analog select, change mask
   localparam logic [7:0] IDX_CORE_STATUS = 8'hF1; // request, wake, vector state
   localparam logic [7:0] IDX_PORT_VALUE = 8'hF2; // port read, refreshes change latch
   // interrupt control fields
   localparam int ICR_GIE = 7;
   localparam int ICR_PERIPHERAL_IRQ_ENABLE = 6;
   localparam int ICR_TIMER0_OVERFLOW_ENABLE = 5;
   localparam int ICR_EXTE = 4;
   localparam int ICR_PCE = 3;
   localparam int ICR_T0F = 2;
   localparam int ICR_EXTF = 1;
   localparam int ICR_PCF = 0;
   // peripheral flag and enable fields
   localparam int PF_NVM = 7;
   localparam int PF_CONV = 6;
   localparam int PF_CMP = 3;
   localparam int PF_TMR1 = 0;
   localparam logic [7:0] PF_MASK = 8'hC9; // implemented peripheral bits
   // aux control fields
   localparam int AUX_POL = 0; // edge_polarity_select
   localparam int AUX_ANALOG_SELECT_LSB = 8; // analog_select [13:8]
   localparam int AUX_MASK_LSB = 16; // change_pin_mask [21:16]
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [31:0] AUX_RESET = 32'h00000001;
   localparam logic [15:0] VECTOR_ADDR = 16'h0004;
   localparam logic [1:0] PH_Q1 = 2'h0;
   localparam logic [1:0] PH_Q2 = 2'h1;
   localparam logic [1:0] PH_Q3 = 2'h2;
   localparam logic [1:0] PH_Q4 = 2'h3;
   // peripheral event strobes travel together
   typedef struct packed {
      logic nvm_done;
      logic conv_done;
      logic comparator;
      logic timer1_ovf;
   } mic_periph_ev_t;
   // core handshake to sequencer
   typedef struct packed {
      logic irq_req;
      logic wake;
      logic vector_load;
      logic push_pc;
   } mic_core_out_t;
endpackage : mic_pkg

//--- mic_seq_model.sv
// partner: sequencer model stepping instruction phases and issuing return pulses
`timescale 1ns/1ps
module mic_seq_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ret_go,
   output logic [1:0] q_phase,
   output logic return_from_irq_instr
);
   // phase steps every clock, so a request can never wait long for q1
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_phase <= mic_pkg::PH_Q1;
      end else begin
         q_phase <= q_phase + 2'h1;
      end
   end
   // return only when the bench asks, one clock after ret_go
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         return_from_irq_instr <= 1'b0;
      end else begin
         return_from_irq_instr <= ret_go;
      end
   end
endmodule : mic_seq_model

//--- tb.sv
// testbench: register access, event flags, gating and vectoring
`timescale 1ns/1ps
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slverr;
   logic timer0_wrap, sleeping, gie_clear_instr, ret_go, return_from_irq_instr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [5:0] port_in;
   logic [1:0] q_phase;
   logic [15:0] vector_addr_q;
   mic_pkg::mic_periph_ev_t periph_ev;
   mic_pkg::mic_core_out_t core_out_q;
   int failures, n_checks;
   mic_combiner dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port_in(port_in), .q_phase(q_phase), .timer0_wrap(timer0_wrap),
      .periph_ev(periph_ev), .sleeping(sleeping), .return_from_irq_instr(return_from_irq_instr),
      .gie_clear_instr(gie_clear_instr), .core_out_q(core_out_q), .vector_addr_q(vector_addr_q));
   mic_seq_model seq_u (.pclk(pclk), .presetn(presetn), .ret_go(ret_go), .q_phase(q_phase),
      .return_from_irq_instr(return_from_irq_instr));
   // free-running 125 MHz clock
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   task automatic stop_test;
      if (failures == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : stop_test
   // one comparison, counted and reported at once
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask : chk
   // apb transfer; an idle edge after it keeps psel from being set twice in a step
   task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'h0, i, 2'h0};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         failures++;
         stop_test();
      end
      rdv = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // pin change launched so the design sees it in q4
   task automatic pin(input logic v);
      repeat (4) begin
         @(posedge pclk);
         if (q_phase === mic_pkg::PH_Q3) break;
      end
      port_in[2] <= v;
      repeat (3) @(posedge pclk);
      apb(1'b0, mic_pkg::IDX_INTERRUPT_CONTROL, 32'h0);
   endtask : pin
   // bounded wait for the vector pulse and its companions
   task automatic wait_vec;
      int n;
      n = 0;
      while (core_out_q.vector_load !== 1'b1 && n < 12) begin
         @(posedge pclk);
         n++;
      end
      chk(n < 12, 32'h1, "no vector");
      chk(core_out_q.push_pc, 32'h1, "no push");
      chk(vector_addr_q, mic_pkg::VECTOR_ADDR, "vector");
      @(posedge pclk);
      chk(core_out_q.vector_load, 32'h0, "long vector");
   endtask : wait_vec
   initial begin
      {presetn, psel, penable, pwrite, timer0_wrap, sleeping, gie_clear_instr, ret_go} = '0;
      {paddr, pwdata, port_in, periph_ev, failures, n_checks} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      // reset values, reserved bits, unmapped index
      apb(1'b0, mic_pkg::IDX_CONTROL_AUX, 32'h0);
      chk(rdv, mic_pkg::AUX_RESET, "aux reset");
      apb(1'b1, mic_pkg::IDX_PERIPHERAL_ENABLES, 32'hFF);
      apb(1'b0, mic_pkg::IDX_PERIPHERAL_ENABLES, 32'h0);
      chk(rdv, {24'h0, mic_pkg::PF_MASK}, "enables");
      apb(1'b0, 8'h10, 32'h0);
      chk({slverr, rdv}, {1'b1, 32'h0}, "unmapped");
      apb(1'b1, mic_pkg::IDX_PERIPHERAL_ENABLES, 32'h0);
      // pin edges under both polarities, then as analog
      pin(1'b1);
      chk(rdv, 32'h2, "rise");
      apb(1'b1, mic_pkg::IDX_INTERRUPT_CONTROL, 32'h0);
      pin(1'b0);
      chk(rdv, 32'h0, "fall flagged");
      apb(1'b1, mic_pkg::IDX_CONTROL_AUX, 32'h0);
      pin(1'b1);
      chk(rdv, 32'h0, "rise flagged");
      pin(1'b0);
      chk(rdv, 32'h2, "fall");
      apb(1'b1, mic_pkg::IDX_INTERRUPT_CONTROL, 32'h0);
      apb(1'b1, mic_pkg::IDX_CONTROL_AUX, 32'h401);
      pin(1'b1);
      chk(rdv, 32'h0, "analog edge");
      // drop the pin while still analog so re-enabling the digital path makes no edge
      port_in[2] <= 1'b0;
      // timer0 flag, gating, vectoring and return
      apb(1'b1, mic_pkg::IDX_INTERRUPT_CONTROL, 32'h80);
      timer0_wrap <= 1'b1;
      @(posedge pclk);
      timer0_wrap <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(core_out_q.irq_req, 32'h0, "gated");
      apb(1'b1, mic_pkg::IDX_INTERRUPT_CONTROL, 32'hA4);
      wait_vec();
      apb(1'b0, mic_pkg::IDX_INTERRUPT_CONTROL, 32'h0);
      chk(rdv, 32'h24, "gie kept");
      apb(1'b1, mic_pkg::IDX_INTERRUPT_CONTROL, 32'h20);
      ret_go <= 1'b1;
      @(posedge pclk);
      ret_go <= 1'b0;
      repeat (2) @(posedge pclk);
      apb(1'b0, mic_pkg::IDX_INTERRUPT_CONTROL, 32'h0);
      chk(rdv, 32'hA0, "no return");
      // masked port change, latch refresh, wake without gie
      apb(1'b1, mic_pkg::IDX_INTERRUPT_CONTROL, 32'h0);
      apb(1'b1, mic_pkg::IDX_CONTROL_AUX, 32'h10001);
      apb(1'b0, mic_pkg::IDX_PORT_VALUE, 32'h0);
      port_in[0] <= 1'b1;
      repeat (3) @(posedge pclk);
      apb(1'b0, mic_pkg::IDX_INTERRUPT_CONTROL, 32'h0);
      chk(rdv, 32'h1, "change");
      // refresh the latch first, else the stale change sets the flag again
      apb(1'b0, mic_pkg::IDX_PORT_VALUE, 32'h0);
      apb(1'b1, mic_pkg::IDX_INTERRUPT_CONTROL, 32'h8);
      port_in[1] <= 1'b1;
      sleeping <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(core_out_q.wake, 32'h0, "unmasked pin");
      port_in[0] <= 1'b0;
      repeat (3) @(posedge pclk);
      chk({core_out_q.wake, core_out_q.irq_req}, 32'h2, "wake");
      sleeping <= 1'b0;
      apb(1'b1, mic_pkg::IDX_INTERRUPT_CONTROL, 32'h0);
      // conversion done through the peripheral path
      periph_ev.conv_done <= 1'b1;
      @(posedge pclk);
      periph_ev.conv_done <= 1'b0;
      apb(1'b0, mic_pkg::IDX_PERIPHERAL_FLAGS, 32'h0);
      chk(rdv, 32'h40, "conv flag");
      apb(1'b1, mic_pkg::IDX_INTERRUPT_CONTROL, 32'hC0);
      chk(core_out_q.irq_req, 32'h0, "conv gated");
      apb(1'b1, mic_pkg::IDX_PERIPHERAL_ENABLES, 32'h40);
      wait_vec();
      // return sets gie, a clear right after it defers the still pending request
      ret_go <= 1'b1;
      @(posedge pclk);
      ret_go <= 1'b0;
      @(posedge pclk);
      gie_clear_instr <= 1'b1;
      @(posedge pclk);
      gie_clear_instr <= 1'b0;
      repeat (8) begin
         @(posedge pclk);
         if (core_out_q.vector_load === 1'b1) chk(32'h1, 32'h0, "not deferred");
      end
      apb(1'b0, mic_pkg::IDX_PERIPHERAL_FLAGS, 32'h0);
      chk(rdv, 32'h40, "pending lost");
      ret_go <= 1'b1;
      @(posedge pclk);
      ret_go <= 1'b0;
      wait_vec();
      stop_test();
   end
endmodule : tb
